//--- logic/ssfb_pkg.sv
// Constants, register map and frame layout of the SPI status-flag bank
//
// How it works
// (RQ1) A status frame is sixteen bits: address byte first, then data byte.
// (RQ2) The first byte holds a seven-bit address and one access-mode bit.
// (RQ3) Register bits 0..7 travel in frame bits 8..15, the data byte.
// (RQ4) Frame bit 7 low reads the register and leaves it unchanged.
// (RQ5) Frame bit 7 high clears every clearable flag of the register.
// (RQ6) Each bit is read-only or read-clear; clear zeroes only read-clear bits.
// (RQ7) Flags stay set until cleared by a frame; watchdog count may change.
// (RQ8) Supply-fail register resets to zero; restart zeroes bits 7, 4, 3, 2.
// (RQ9) Bit 6 sets on battery undervoltage, only while core regulator is on.
// (RQ10) Bit 5 sets on battery overvoltage, only while core regulator is on; the code also sets it with charge pump on.
// (RQ11) Bit 1 sets on core regulator overvoltage, else reads zero.
// (RQ12) Bit 0 sets on core regulator undervoltage prewarning, else zero.
// (RQ13) Stop mode halts undervoltage check unless peak load or prewarning.
// (RQ14) Overvoltage check always runs with charge pump on, else like RQ13.
// (RQ15) A clear frame returns the old contents, then applies the clear.
package ssfb_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int SSFB_FRAME_BITS = 16;
  localparam int SSFB_ADDR_BITS = 7;
  localparam int SSFB_MODE_BIT = 7;
  localparam int SSFB_DATA_LSB = 8;
  localparam int SSFB_DATA_BITS = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [6:0] SSFB_OFS_SUP1 = 7'h40;
  localparam logic [6:0] SSFB_OFS_SUP0 = 7'h41;
  localparam logic [6:0] SSFB_OFS_THERM = 7'h42;
  localparam logic [6:0] SSFB_OFS_DEV = 7'h43;
  localparam logic [6:0] SSFB_OFS_BUS = 7'h44;
  localparam logic [6:0] SSFB_OFS_WK0 = 7'h46;
  localparam logic [6:0] SSFB_OFS_WK1 = 7'h47;
  localparam logic [6:0] SSFB_OFS_WKLVL = 7'h48;
  localparam logic [6:0] SSFB_OFS_GPOC = 7'h54;
  localparam logic [6:0] SSFB_OFS_GPOL = 7'h55;
  localparam logic [6:0] SSFB_OFS_SWK = 7'h70;
  localparam logic [6:0] SSFB_OFS_SWKEC = 7'h71;
  localparam logic [6:0] SSFB_OFS_CDR1 = 7'h72;
  localparam logic [6:0] SSFB_OFS_CDR2 = 7'h73;
  localparam logic [6:0] SSFB_OFS_FAMID = 7'h7e;

  // ****************************************
  // Supply-fail status 1 fields and reset values
  // ****************************************
  localparam int SSFB_BIT_BAT_UV = 6;
  localparam int SSFB_BIT_BAT_OV = 5;
  localparam int SSFB_BIT_CORE_OV = 1;
  localparam int SSFB_BIT_CORE_PW = 0;
  localparam logic [7:0] SSFB_SUP1_RESET = 8'h00;
  localparam logic [7:0] SSFB_SUP1_CLR_MASK = 8'h63;
  // Bits that survive a restart (x positions of 0xx0 00xx)
  localparam logic [7:0] SSFB_SUP1_RESTART_KEEP = 8'h63;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SSFB_MODE_NORMAL = 2'b00,
    SSFB_MODE_STOP = 2'b01,
    SSFB_MODE_OTHER = 2'b10
  } ssfb_mode_e;

  // Raw supply monitor events and their qualifiers
  typedef struct packed {
    logic bat_uv;
    logic bat_ov;
    logic core_ov;
    logic core_pw;
    logic core_on;
    logic load_peak;
    logic charge_pump_enable;
  } ssfb_mon_s;

  // One decoded frame from the shift logic
  typedef struct packed {
    logic valid;
    logic clear;
    logic [6:0] addr;
  } ssfb_req_s;

endpackage : ssfb_pkg

//--- logic/ssfb_supply_mon.sv
// Supply monitor gating and sticky supply-fail status 1 register
module ssfb_supply_mon
  import ssfb_pkg::*;
(
  // Clock and resets
  input wire logic clock,
  input wire logic rst,
  input wire logic restart,
  // Monitor inputs
  input wire ssfb_mon_s mon,
  input wire ssfb_mode_e mode,
  // Clear strobe
  input wire logic clear,
  // Register value
  output logic [7:0] status
);

  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] set_vec;
  logic stop_exempt;
  logic uv_enable;
  logic ov_enable;

  // ****************************************
  // Detection gating
  // ****************************************
  // Peak load or a live or latched prewarning keeps battery checks on in Stop mode
  assign stop_exempt = mon.load_peak | mon.core_pw |
                       status_reg[SSFB_BIT_CORE_PW]; // [RQ13]
  assign uv_enable = mon.core_on &
                     ((mode != SSFB_MODE_STOP) | stop_exempt); // [RQ9] [RQ13]
  assign ov_enable = mon.charge_pump_enable |
                     (mon.core_on &
                      ((mode != SSFB_MODE_STOP) | stop_exempt)); // [RQ10] [RQ14]

  always_comb begin
    set_vec = 8'h00;
    set_vec[SSFB_BIT_BAT_UV] = mon.bat_uv & uv_enable; // [RQ9]
    set_vec[SSFB_BIT_BAT_OV] = mon.bat_ov & ov_enable; // [RQ10]
    set_vec[SSFB_BIT_CORE_OV] = mon.core_ov; // [RQ11]
    set_vec[SSFB_BIT_CORE_PW] = mon.core_pw; // [RQ12]
  end

  // Set wins over a clear in the same cycle; only rc bits can clear
  assign status_next = ((clear ? (status_reg & ~SSFB_SUP1_CLR_MASK)
                               : status_reg) | set_vec) &
                       SSFB_SUP1_CLR_MASK; // [RQ5] [RQ6] [RQ7]

  always_ff @(posedge clock) begin
    if (rst) begin
      status_reg <= SSFB_SUP1_RESET; // [RQ8]
    end else if (restart) begin
      status_reg <= status_next & SSFB_SUP1_RESTART_KEEP; // [RQ8]
    end else begin
      status_reg <= status_next;
    end
  end

  assign status = status_reg;

endmodule : ssfb_supply_mon

//--- logic/ssfb_status_bank.sv
// SPI status register bank: frame decode, read-back and byte-wise clear
module ssfb_status_bank
  import ssfb_pkg::*;
(
  // Clock and resets
  input wire logic clock,
  input wire logic rst,
  input wire logic restart,
  // Frame from the SPI shift logic
  input wire logic frame_valid,
  input wire logic [15:0] frame_in,
  // Answer data byte
  output logic [7:0] read_data,
  output logic read_valid,
  output logic addr_hit,
  // Supply monitoring
  input wire ssfb_mon_s mon,
  input wire ssfb_mode_e mode,
  // Other status registers: live values and rc masks from their owners
  input wire logic [7:0] ext_value [14],
  input wire logic [7:0] ext_clear_mask [14],
  output logic [13:0] ext_clear
);

  // ****************************************
  // Frame decode
  // ****************************************
  ssfb_req_s req;
  logic [7:0] sup1_value;
  logic sup1_sel;
  logic [3:0] ext_idx;
  logic ext_sel;
  logic [7:0] read_mux;
  logic [7:0] read_data_reg;
  logic read_valid_reg;
  logic addr_hit_reg;

  assign req.valid = frame_valid; // [RQ1]
  assign req.addr = frame_in[SSFB_ADDR_BITS-1:0]; // [RQ2]
  // Incoming data byte is ignored for status access
  assign req.clear = frame_in[SSFB_MODE_BIT]; // [RQ4] [RQ5]

  // Index of one of the other status registers, used twice
  function automatic logic [4:0] ext_decode(input logic [6:0] a);
    logic [4:0] r;
    r = 5'h1f;
    if (a == SSFB_OFS_SUP0) begin
      r = 5'h00;
    end else if (a == SSFB_OFS_THERM) begin
      r = 5'h01;
    end else if (a == SSFB_OFS_DEV) begin
      r = 5'h02;
    end else if (a == SSFB_OFS_BUS) begin
      r = 5'h03;
    end else if (a == SSFB_OFS_WK0) begin
      r = 5'h04;
    end else if (a == SSFB_OFS_WK1) begin
      r = 5'h05;
    end else if (a == SSFB_OFS_WKLVL) begin
      r = 5'h06;
    end else if (a == SSFB_OFS_GPOC) begin
      r = 5'h07;
    end else if (a == SSFB_OFS_GPOL) begin
      r = 5'h08;
    end else if (a == SSFB_OFS_SWK) begin
      r = 5'h09;
    end else if (a == SSFB_OFS_SWKEC) begin
      r = 5'h0a;
    end else if (a == SSFB_OFS_CDR1) begin
      r = 5'h0b;
    end else if (a == SSFB_OFS_CDR2) begin
      r = 5'h0c;
    end else if (a == SSFB_OFS_FAMID) begin
      r = 5'h0d;
    end
    return r;
  endfunction : ext_decode

  logic [4:0] ext_code;
  assign ext_code = ext_decode(req.addr);
  assign ext_sel = (ext_code != 5'h1f);
  assign ext_idx = ext_code[3:0];
  assign sup1_sel = (req.addr == SSFB_OFS_SUP1);

  // ****************************************
  // Supply-fail status 1
  // ****************************************
  ssfb_supply_mon u_supply_mon (
    .clock(clock),
    .rst(rst),
    .restart(restart),
    .mon(mon),
    .mode(mode),
    .clear(req.valid & req.clear & sup1_sel), // [RQ5]
    .status(sup1_value)
  );

  // ****************************************
  // Clear strobes to the other registers
  // ****************************************
  // Owners clear only bits in their rc mask; watchdog count is theirs
  genvar gi;
  generate
    for (gi = 0; gi < 14; gi++) begin : g_clr
      assign ext_clear[gi] = req.valid & req.clear & ext_sel &
                             (ext_idx == 4'(gi)) &
                             (|ext_clear_mask[gi]); // [RQ5] [RQ6] [RQ7]
    end
  endgenerate

  // ****************************************
  // Read-back
  // ****************************************
  // Value sampled before the clear lands, so a clear frame returns it
  assign read_mux = sup1_sel ? sup1_value :
                    ext_sel ? ext_value[ext_idx] : 8'h00; // [RQ15] [RQ4]

  always_ff @(posedge clock) begin
    if (rst) begin
      read_data_reg <= 8'h00;
      read_valid_reg <= 1'b0;
      addr_hit_reg <= 1'b0;
    end else begin
      read_valid_reg <= req.valid;
      if (req.valid) begin
        read_data_reg <= read_mux; // [RQ3] [RQ15]
        addr_hit_reg <= sup1_sel | ext_sel;
      end
    end
  end

  assign read_data = read_data_reg;
  assign read_valid = read_valid_reg;
  assign addr_hit = addr_hit_reg;

endmodule : ssfb_status_bank

//--- tb/ssfb_bank_sva.sv
// Port assertions for the status bank
module ssfb_bank_sva
  import ssfb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Frame and answer
  input wire logic frame_valid,
  input wire logic [15:0] frame_in,
  input wire logic [7:0] read_data,
  input wire logic read_valid,
  input wire logic addr_hit,
  // Other registers
  input wire logic [7:0] ext_value [14],
  input wire logic [7:0] ext_clear_mask [14],
  input wire logic [13:0] ext_clear
);
  // ****************************************
  // Properties
  // ****************************************
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  wire logic hit40 = frame_valid && frame_in[6:0] == 7'h40;
  wire logic hit41 = frame_valid && frame_in[6:0] == 7'h41;
  chk_answer_lat:
  assert property (frame_valid |=> read_valid) else $error("late answer");
  chk_no_spurious:
  assert property (read_valid |-> $past(frame_valid)) else $error("spurious");
  chk_addr_hit:
  assert property (hit40 |=> addr_hit) else $error("hit missing");
  chk_data_byte:
  assert property (hit41 |=> read_data == $past(ext_value[0]))
    else $error("bad data byte");
  chk_unmapped_zero:
  assert property (read_valid && !addr_hit |-> read_data == 8'h00)
    else $error("unmapped data");
  chk_reserved_zero:
  assert property (hit40 |=> !read_data[7] && read_data[4:2] == 3'h0)
    else $error("reserved bit set");
  chk_clear_strobe:
  assert property (hit41 && frame_in[7] && ext_clear_mask[0] != 8'h00
    |-> ext_clear[0]) else $error("clear missing");
  chk_read_keeps:
  assert property (!(frame_valid && frame_in[7]) |-> ext_clear == 14'h0)
    else $error("clear on read");
  chk_answer_stands:
  assert property (!frame_valid |=> $stable(read_data))
    else $error("answer moved");
  cover property (hit40 && frame_in[7]);
  cover property (read_valid && !addr_hit);
  cover property (ext_clear != 14'h0);
endmodule : ssfb_bank_sva

bind ssfb_status_bank ssfb_bank_sva ssfb_bank_sva_i (.clock, .rst,
  .frame_valid, .frame_in, .read_data, .read_valid, .addr_hit,
  .ext_value, .ext_clear_mask, .ext_clear);

//--- tb/ssfb_master_model.sv
// Controller side: turns a bench request into one whole frame
module ssfb_master_model
  import ssfb_pkg::*;
(
  // Clock
  input wire logic clock,
  // Request
  input wire logic go,
  input wire logic clr,
  input wire logic [6:0] addr,
  // Frame
  output logic frame_valid = 1'b0,
  output logic [15:0] frame_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Data byte is unused by the device, so it toggles
  logic [7:0] fill_reg = 8'h5a;
  always_ff @(posedge clock) begin
    frame_valid <= go;
    frame_in <= {fill_reg, clr, addr};
    fill_reg <= ~fill_reg;
  end
endmodule : ssfb_master_model

//--- tb/tb_top.sv
// Self-checking bench of the status bank
module tb_top import ssfb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic restart = 1'b0;
  logic go = 1'b0;
  logic clr = 1'b0;
  logic [6:0] addr = 7'h00;
  logic frame_valid;
  logic [15:0] frame_in;
  logic [7:0] read_data;
  logic read_valid;
  logic addr_hit;
  ssfb_mon_s mon = '0;
  ssfb_mode_e mode = SSFB_MODE_NORMAL;
  logic [7:0] ext_value [14];
  logic [7:0] ext_clear_mask [14];
  logic [13:0] ext_clear;
  logic [13:0] clr_seen = 14'h0;
  int err_count = 0;
  int total_checks = 0;
  // Rows: address, hit, data
  logic [15:0] rows [15] = '{{7'h41, 1'b1, 8'h80}, {7'h42, 1'b1, 8'h81},
    {7'h43, 1'b1, 8'h82}, {7'h44, 1'b1, 8'h83}, {7'h46, 1'b1, 8'h84},
    {7'h47, 1'b1, 8'h85}, {7'h48, 1'b1, 8'h86}, {7'h54, 1'b1, 8'h87},
    {7'h55, 1'b1, 8'h88}, {7'h70, 1'b1, 8'h89}, {7'h71, 1'b1, 8'h8a},
    {7'h72, 1'b1, 8'h8b}, {7'h73, 1'b1, 8'h8c}, {7'h7e, 1'b1, 8'h8d},
    {7'h45, 1'b0, 8'h00}};
  ssfb_master_model ssfb_master_model_i (.clock, .go, .clr, .addr,
    .frame_valid, .frame_in);
  ssfb_status_bank ssfb_status_bank_i (.clock, .rst, .restart,
    .frame_valid, .frame_in, .read_data, .read_valid, .addr_hit, .mon,
    .mode, .ext_value, .ext_clear_mask, .ext_clear);
  initial forever #4 clock = ~clock;
  // Clear strobes seen on the last frame edge
  always @(posedge clock) begin
    if (frame_valid) begin
      clr_seen <= ext_clear;
    end
  end
  task automatic chk_clr(input logic [13:0] got, input logic [13:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_clr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic [6:0] a, input logic c);
    @(posedge clock);
    go <= 1'b1;
    addr <= a;
    clr <= c;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    #1;
  endtask : xfer
  task automatic sup(input logic c, input logic [7:0] e);
    xfer(7'h40, c);
    chk(read_data, e);
    chk_clr(clr_seen, 14'h0);
  endtask : sup
  task automatic ev(input ssfb_mon_s m, input ssfb_mode_e md);
    @(posedge clock);
    mon <= m;
    mode <= md;
    @(posedge clock);
    mon <= '0;
    mode <= SSFB_MODE_NORMAL;
  endtask : ev
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    for (int i = 0; i < 14; i++) begin
      ext_value[i] = 8'h80 | 8'(i);
      ext_clear_mask[i] = (i == 2) ? 8'h00 : 8'h0f;
    end
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    sup(1'b0, 8'h00);
    foreach (rows[i]) begin
      xfer(rows[i][15:9], 1'b0);
      chk(read_data, rows[i][7:0]);
      chk({7'h0, addr_hit}, {7'h0, rows[i][8]});
      chk_clr(clr_seen, 14'h0);
      xfer(rows[i][15:9], 1'b1);
      chk_clr(clr_seen, 14'(i != 2 && i < 14) << i);
    end
    ev(7'h44, SSFB_MODE_NORMAL);
    sup(1'b0, 8'h40);
    sup(1'b0, 8'h40);
    sup(1'b1, 8'h40);
    sup(1'b0, 8'h00);
    ev(7'h20, SSFB_MODE_NORMAL);
    sup(1'b0, 8'h00);
    ev(7'h18, SSFB_MODE_NORMAL);
    sup(1'b0, 8'h03);
    @(posedge clock);
    restart <= 1'b1;
    @(posedge clock);
    restart <= 1'b0;
    sup(1'b1, 8'h03);
    ev(7'h44, SSFB_MODE_STOP);
    sup(1'b0, 8'h00);
    ev(7'h46, SSFB_MODE_STOP);
    sup(1'b1, 8'h40);
    ev(7'h24, SSFB_MODE_STOP);
    sup(1'b0, 8'h00);
    ev(7'h25, SSFB_MODE_STOP);
    sup(1'b1, 8'h20);
    ev(7'h24, SSFB_MODE_NORMAL);
    sup(1'b1, 8'h20);
    ev(7'h44, SSFB_MODE_OTHER);
    sup(1'b1, 8'h40);
    ev(7'h4c, SSFB_MODE_STOP);
    sup(1'b1, 8'h41);
    ev(7'h08, SSFB_MODE_NORMAL);
    ev(7'h44, SSFB_MODE_STOP);
    sup(1'b1, 8'h41);
    ev(7'h21, SSFB_MODE_STOP);
    sup(1'b1, 8'h20);
    ev(7'h18, SSFB_MODE_NORMAL);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    sup(1'b0, 8'h00);
    give_verdict();
  end
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end
endmodule : tb_top
